/* rtl/desc_attr_pkg.sv */
// Package: offsets, field layouts and reset values of the descriptor attribute registers
package desc_attr_pkg;
   localparam logic [11:0] STRING_LENGTH_ATTRS_A_OFS = 12'h0a8;
   localparam logic [11:0] STRING_LENGTH_ATTRS_B_OFS = 12'h0ac;
   localparam logic [11:0] CONFIG_WAKE_FLAG_ATTRS_OFS = 12'h0b0;
   localparam logic [11:0] ATTR_CONTROL_OFS = 12'h0b4;
   localparam logic [11:0] ATTR_STATUS_OFS = 12'h0b8;
   localparam logic [7:0] LENGTH_RESET = 8'h00;
   localparam logic [7:0] WAKE_FLAGS_RESET = 8'h00;
   localparam int REMOTE_WAKEUP_BIT = 17;
   localparam int POWER_METHOD_BIT = 16;
   localparam int LEN_W = 8;
   localparam int EMU_ENABLE_BIT = 0;
   localparam int EEPROM_PRESENT_BIT = 0;
   localparam int ATTRS_ACTIVE_BIT = 1;
   localparam int BAD_WRITE_BIT = 2;
   // Enabled edges after reset release before the synchronised straps are valid
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   typedef struct packed {
      logic [7:0] config_string_length;
      logic [7:0] serial_string_length;
      logic [7:0] product_string_length;
      logic [7:0] maker_string_length;
      logic [7:0] interface_string_length;
   } string_lengths_t;

   typedef struct packed {
      logic remote_wakeup_capable;
      logic power_method_select;
      logic [7:0] gpio_wake_flags;
   } config_flags_t;

   typedef struct packed {
      logic remote_wakeup_capable;
      logic power_method_select;
   } straps_t;
endpackage : desc_attr_pkg

/* rtl/strap_sync.sv */
// Two-stage synchroniser for strap and presence pins
`timescale 1ns/1ns
module strap_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;

   always_comb begin
      meta_nxt = clk_en ? async_in : meta_r;
      sync_nxt = clk_en ? meta_r : sync_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;
endmodule : strap_sync

/* rtl/apb_slave_if.sv */
// APB slave front end: two-cycle access phase (one wait state), write and read strobes
`timescale 1ns/1ns
module apb_slave_if (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   // Strobes to register file
   output logic wr_stb,
   output logic rd_stb,
   output logic [11:0] acc_addr,
   output logic pready
);
   logic ready_r;
   logic ready_nxt;

   always_comb begin
      ready_nxt = ready_r;
      if (clk_en) begin
         ready_nxt = psel && penable && !ready_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= ready_nxt;
      end
   end

   assign pready = ready_r;
   assign wr_stb = clk_en && psel && penable && ready_r && pwrite;
   assign rd_stb = clk_en && psel && penable && !ready_r && !pwrite;
   assign acc_addr = paddr;
endmodule : apb_slave_if

/* rtl/descriptor_ram_attribute_regs.sv */
// Descriptor RAM attribute registers: string lengths and configuration/wake flags
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module descriptor_ram_attribute_regs (
   // Clock, enable and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic protected_reset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire desc_attr_pkg::straps_t strap_pins,
   input wire logic eeprom_detected,
   // To descriptor processing
   output desc_attr_pkg::string_lengths_t string_lengths,
   output desc_attr_pkg::config_flags_t config_flags,
   output logic attrs_active
);
   import desc_attr_pkg::*;

   logic wr_stb;
   logic rd_stb;
   logic [11:0] acc_addr;
   logic apb_ready;
   logic [1:0] strap_sync_w;
   logic eeprom_sync;
   straps_t straps_s;

   apb_slave_if u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .acc_addr(acc_addr),
      .pready(apb_ready)
   );

   strap_sync #(.W(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .async_in({strap_pins, eeprom_detected}),
      .sync_out({strap_sync_w, eeprom_sync})
   );
   assign straps_s = straps_t'(strap_sync_w);

   // Address decode used for both read and write
   function automatic logic [2:0] reg_sel(input logic [11:0] a);
      logic [2:0] s;
      s = 3'h0;
      if (a == STRING_LENGTH_ATTRS_A_OFS) begin
         s = 3'h1;
      end else if (a == STRING_LENGTH_ATTRS_B_OFS) begin
         s = 3'h2;
      end else if (a == CONFIG_WAKE_FLAG_ATTRS_OFS) begin
         s = 3'h3;
      end else if (a == ATTR_CONTROL_OFS) begin
         s = 3'h4;
      end else if (a == ATTR_STATUS_OFS) begin
         s = 3'h5;
      end
      return s;
   endfunction : reg_sel

   string_lengths_t lens_r;
   string_lengths_t lens_nxt;
   config_flags_t flags_r;
   config_flags_t flags_nxt;
   logic emu_en_r;
   logic emu_en_nxt;
   logic bad_wr_r;
   logic bad_wr_nxt;
   logic strap_load_r;
   logic strap_load_nxt;
   logic [1:0] strap_cnt_r;
   logic [1:0] strap_cnt_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic err_r;
   logic err_nxt;
   logic active_r;
   logic active_nxt;
   logic [2:0] sel;

   assign sel = reg_sel(acc_addr);

   // Register state
   always_comb begin
      lens_nxt = lens_r;
      flags_nxt = flags_r;
      emu_en_nxt = emu_en_r;
      bad_wr_nxt = bad_wr_r;
      strap_load_nxt = strap_load_r;
      strap_cnt_nxt = strap_cnt_r;
      if (clk_en) begin
         // Strap defaults caught once, after the synchroniser has refilled from reset
         if (strap_load_r) begin
            if (strap_cnt_r != 2'h0) begin
               strap_cnt_nxt = strap_cnt_r - 2'h1;
            end else begin
               flags_nxt.remote_wakeup_capable = straps_s.remote_wakeup_capable;
               flags_nxt.power_method_select = straps_s.power_method_select;
               strap_load_nxt = 1'b0;
            end
         end
         if (wr_stb) begin
            if (sel == 3'h1) begin
               lens_nxt.config_string_length = pwdata[31:24];
               lens_nxt.serial_string_length = pwdata[23:16];
               lens_nxt.product_string_length = pwdata[15:8];
               lens_nxt.maker_string_length = pwdata[7:0];
            end else if (sel == 3'h2) begin
               lens_nxt.interface_string_length = pwdata[7:0];
            end else if (sel == 3'h3) begin
               flags_nxt.remote_wakeup_capable = pwdata[REMOTE_WAKEUP_BIT];
               flags_nxt.power_method_select = pwdata[POWER_METHOD_BIT];
               flags_nxt.gpio_wake_flags = pwdata[7:0];
            end else if (sel == 3'h4) begin
               emu_en_nxt = pwdata[EMU_ENABLE_BIT];
            end else if (sel == 3'h5) begin
               bad_wr_nxt = bad_wr_r && !pwdata[BAD_WRITE_BIT];
            end
            // Writes to the A, B and flag registers with EEPROM fitted are recorded; set beats clear
            if (eeprom_sync && (sel == 3'h1 || sel == 3'h2 || sel == 3'h3)) begin
               bad_wr_nxt = 1'b1;
            end
         end
      end
   end

   // Without the clock, attribute state holds; only a power-on reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lens_r <= '{LENGTH_RESET, LENGTH_RESET, LENGTH_RESET, LENGTH_RESET, LENGTH_RESET};
         flags_r <= '{1'b0, 1'b0, WAKE_FLAGS_RESET};
         emu_en_r <= 1'b0;
         bad_wr_r <= 1'b0;
         strap_load_r <= 1'b1;
         strap_cnt_r <= STRAP_SETTLE;
      end else begin
         // Protected reset is not applied to these registers
         lens_r <= lens_nxt;
         flags_r <= flags_nxt;
         emu_en_r <= emu_en_nxt;
         bad_wr_r <= bad_wr_nxt;
         strap_load_r <= strap_load_nxt;
         strap_cnt_r <= strap_cnt_nxt;
      end
   end

   // Read path and bus answer
   always_comb begin
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      active_nxt = active_r;
      if (clk_en) begin
         active_nxt = !eeprom_sync && emu_en_r && !protected_reset;
         err_nxt = 1'b0;
         if (rd_stb || (psel && penable && !apb_ready)) begin
            err_nxt = (sel == 3'h0);
         end
         if (rd_stb) begin
            rdata_nxt = 32'h0000_0000;
            if (sel == 3'h1) begin
               rdata_nxt = {lens_r.config_string_length, lens_r.serial_string_length,
                            lens_r.product_string_length, lens_r.maker_string_length};
            end else if (sel == 3'h2) begin
               rdata_nxt[LEN_W-1:0] = lens_r.interface_string_length;
            end else if (sel == 3'h3) begin
               rdata_nxt[REMOTE_WAKEUP_BIT] = flags_r.remote_wakeup_capable;
               rdata_nxt[POWER_METHOD_BIT] = flags_r.power_method_select;
               rdata_nxt[7:0] = flags_r.gpio_wake_flags;
            end else if (sel == 3'h4) begin
               rdata_nxt[EMU_ENABLE_BIT] = emu_en_r;
            end else if (sel == 3'h5) begin
               rdata_nxt[EEPROM_PRESENT_BIT] = eeprom_sync;
               rdata_nxt[ATTRS_ACTIVE_BIT] = active_r;
               rdata_nxt[BAD_WRITE_BIT] = bad_wr_r;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
         active_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
         active_r <= active_nxt;
      end
   end

   // Outputs to descriptor processing, zero unless running from RAM images
   string_lengths_t lens_out_r;
   string_lengths_t lens_out_nxt;
   config_flags_t flags_out_r;
   config_flags_t flags_out_nxt;

   always_comb begin
      lens_out_nxt = lens_out_r;
      flags_out_nxt = flags_out_r;
      if (clk_en) begin
         // Same-cycle switch with attrs_active, so no stale value leaks out
         lens_out_nxt = active_nxt ? lens_r : '0;
         flags_out_nxt = active_nxt ? flags_r : '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lens_out_r <= '0;
         flags_out_r <= '0;
      end else begin
         lens_out_r <= lens_out_nxt;
         flags_out_r <= flags_out_nxt;
      end
   end

   assign string_lengths = lens_out_r;
   assign config_flags = flags_out_r;
   assign attrs_active = active_r;
   assign prdata = rdata_r;
   assign pready = apb_ready;
   assign pslverr = err_r;
endmodule : descriptor_ram_attribute_regs

/* tb/desc_attr_assertions.sv */
// Checker for the descriptor attribute register bank
`timescale 1ns/1ns
module desc_attr_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Device side
   input wire logic protected_reset,
   input wire logic eeprom_detected,
   input wire desc_attr_pkg::string_lengths_t string_lengths,
   input wire desc_attr_pkg::config_flags_t config_flags,
   input wire logic attrs_active
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready_pulse; pready && clk_en |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
   property p_ready_cause; psel && penable && !pready && clk_en |=> pready; endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("access not answered");
   property p_idle; !psel && clk_en |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("pready without access");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("pslverr without pready");
   property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
   property p_eeprom; (eeprom_detected && clk_en) [*5] |-> !attrs_active; endproperty
   a_eeprom: assert property (p_eeprom) else $error("active with eeprom");
   property p_protect; protected_reset && clk_en |=> !attrs_active; endproperty
   a_protect: assert property (p_protect) else $error("active in protected reset");
   property p_len_off; !attrs_active |-> string_lengths == '0; endproperty
   a_len_off: assert property (p_len_off) else $error("lengths while inactive");
   property p_flag_off; !attrs_active |-> config_flags == '0; endproperty
   a_flag_off: assert property (p_flag_off) else $error("flags while inactive");
   c_write: cover property (psel && penable && pwrite && pready);
   c_err: cover property (pready && pslverr);
   c_prot: cover property (protected_reset ##1 !attrs_active);
endmodule : desc_attr_checker
bind descriptor_ram_attribute_regs desc_attr_checker u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .protected_reset(protected_reset), .eeprom_detected(eeprom_detected), .string_lengths(string_lengths),
   .config_flags(config_flags), .attrs_active(attrs_active));

/* tb/descriptor_ram_attribute_regs_test.sv */
// Self-checking bench for the descriptor attribute registers
`timescale 1ns/1ns
module descriptor_ram_attribute_regs_test;
   import desc_attr_pkg::*;
   logic pclk, presetn, clk_en, protected_reset, psel, penable, pwrite, pready, pslverr, eeprom_detected;
   logic attrs_active, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, a_v, b_v, f_v;
   straps_t strap_pins;
   string_lengths_t string_lengths;
   config_flags_t config_flags;
   int failures = 0;
   int n_tests = 0;
   integer seed = 29056;
   descriptor_ram_attribute_regs DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .protected_reset(protected_reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_pins(strap_pins),
      .eeprom_detected(eeprom_detected), .string_lengths(string_lengths), .config_flags(config_flags),
      .attrs_active(attrs_active));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk32
   // One APB transfer, entered right after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Request held until pready is seen high at a rising edge; the watchdog bounds the wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wait_act(input logic v);
      int k;
      k = 0;
      do begin
         @(negedge pclk);
         k++;
      end while (attrs_active !== v && k < 10);
      chk32("attrs_active", {31'h0, v}, {31'h0, attrs_active});
      chk32("lengths low", v ? {a_v[15:0], 8'h0, b_v[7:0]} : 32'h0,
         {string_lengths[23:8], 8'h0, string_lengths[7:0]});
      chk32("flags", v ? {22'h0, f_v[17:16], f_v[7:0]} : 32'h0, {22'h0, config_flags});
      @(posedge pclk);
   endtask : wait_act
   task automatic stop_test;
      $display("Comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   initial begin
      #300000;
      failures++;
      stop_test;
   end
   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      protected_reset = 1'b0;
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0;
      eeprom_detected = 1'b0;
      strap_pins = 2'b11;
      {a_v, b_v, f_v} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, STRING_LENGTH_ATTRS_A_OFS, 32'h0, q, e);
      chk32("a reset", 32'h0, q);
      apb(1'b0, STRING_LENGTH_ATTRS_B_OFS, 32'h0, q, e);
      chk32("b reset", 32'h0, q);
      apb(1'b0, CONFIG_WAKE_FLAG_ATTRS_OFS, 32'h0, q, e);
      chk32("flag reset", 32'h00030000, q);
      $display("reset values done");
      apb(1'b1, ATTR_CONTROL_OFS, 32'h1, q, e);
      for (int i = 0; i < 24; i++) begin
         a_v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $random(seed);
         b_v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $random(seed);
         f_v = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h0 : $random(seed);
         apb(1'b1, STRING_LENGTH_ATTRS_A_OFS, a_v, q, e);
         apb(1'b1, STRING_LENGTH_ATTRS_B_OFS, b_v, q, e);
         apb(1'b1, CONFIG_WAKE_FLAG_ATTRS_OFS, f_v, q, e);
         apb(1'b0, STRING_LENGTH_ATTRS_A_OFS, 32'h0, q, e);
         chk32("a", a_v, q);
         chk32("a error", 32'h0, {31'h0, e});
         apb(1'b0, STRING_LENGTH_ATTRS_B_OFS, 32'h0, q, e);
         chk32("b", b_v & 32'h000000ff, q);
         apb(1'b0, CONFIG_WAKE_FLAG_ATTRS_OFS, 32'h0, q, e);
         chk32("flag", f_v & 32'h000300ff, q);
         chk32("lengths high", a_v & 32'hffff0000, {string_lengths[39:24], 16'h0});
         wait_act(1'b1);
      end
      $display("readback done");
      apb(1'b1, 12'h0bc, 32'hffffffff, q, e);
      apb(1'b0, 12'h0bc, 32'h0, q, e);
      chk32("unmapped data", 32'h0, q);
      chk32("unmapped error", 32'h1, {31'h0, e});
      eeprom_detected <= 1'b1;
      wait_act(1'b0);
      apb(1'b0, ATTR_STATUS_OFS, 32'h0, q, e);
      chk32("status with eeprom", 32'h1, q);
      eeprom_detected <= 1'b0;
      wait_act(1'b1);
      apb(1'b0, ATTR_STATUS_OFS, 32'h0, q, e);
      chk32("status active", 32'h2, q);
      protected_reset <= 1'b1;
      wait_act(1'b0);
      protected_reset <= 1'b0;
      wait_act(1'b1);
      clk_en <= 1'b0;
      eeprom_detected <= 1'b1;
      repeat (6) @(posedge pclk);
      chk32("frozen active", 32'h1, {31'h0, attrs_active});
      clk_en <= 1'b1;
      eeprom_detected <= 1'b0;
      apb(1'b0, STRING_LENGTH_ATTRS_A_OFS, 32'h0, q, e);
      chk32("a kept", a_v, q);
      $display("eeprom and protection done");
      presetn <= 1'b0;
      strap_pins <= 2'b10;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, STRING_LENGTH_ATTRS_A_OFS, 32'h0, q, e);
      chk32("a after reset", 32'h0, q);
      apb(1'b0, CONFIG_WAKE_FLAG_ATTRS_OFS, 32'h0, q, e);
      chk32("flag after reset", 32'h00020000, q);
      $display("second reset done");
      stop_test;
   end
endmodule : descriptor_ram_attribute_regs_test
